//--- include/slc_cfg.svh
// Constants for the serial link control register bank: offsets, field
// positions, reset values, encodings and pipeline depths.
// Assumes it is included by the package and the top module, by bare name.
//
// Overview of operation
// R1: Marker bit replaces sample LSB when enabled
// R2: Marker latency equals sample path latency
// R3: Enabled marker leaves seven data bits above
// R4: Alignment sequence always reports zero control bits
// R5: Software enables marker receiver alongside insertion
// R6: Link enable resets to one, writable
// R7: Software disables link before reconfiguring it
// R8: Disabled link held reset, serializers powered down
// R9: Disabled link has its clocks gated off
// R10: Disabled link holds multiframe counter reset
// R11: Calibration enabled before link enable set
// R12: Link disabled before calibration enable cleared
// R13: Eight-bit link mode, resets to 0x02
// R14: Mode changes only while link, calibration off
// R15: Only modes permitted by lock accepted
// R16: Frames register holds K-1, resets 0x1F
// R17: Software programs K legal for mode
// R18: 64b/66b modes use K = 256*E/F
// R19: Sync request bit resets one, zero requests
// R20: Software request combines with selected pin
// R21: Stuck-low selected pin keeps request asserted
// R22: Select 0 pin, 1 marker, 2 software
// R23: Reserved bits reset zero, store as written
`ifndef SLC_CFG_SVH
`define SLC_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SLC_ADDR_W 12
`define SLC_OFS_SAMPLE_LSB_CONTROL 12'h160
`define SLC_OFS_LINK_ENABLE 12'h200
`define SLC_OFS_LINK_MODE 12'h201
`define SLC_OFS_FRAMES_M1 12'h202
`define SLC_OFS_SW_SYNC 12'h203
`define SLC_OFS_SYNC_CONTROL 12'h204

// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define SLC_RST_SAMPLE_LSB_CONTROL 8'h00
`define SLC_RST_LINK_ENABLE 8'h01
`define SLC_RST_LINK_MODE 8'h02
`define SLC_RST_FRAMES_M1 8'h1F
`define SLC_RST_SW_SYNC 8'h01
`define SLC_RST_SYNC_CONTROL 8'h00
`define SLC_BIT_MARKER_EN 0
`define SLC_BIT_LINK_EN 0
`define SLC_BIT_SW_SYNC 0
`define SLC_SYNC_SEL_HI 3
`define SLC_SYNC_SEL_LO 2

// ----------------------------------------------------------------------
// Encodings, mode thresholds, depths
// ----------------------------------------------------------------------
`define SLC_SEL_PIN 2'h0
`define SLC_SEL_MARKER 2'h1
`define SLC_SEL_SOFTWARE 2'h2
`define SLC_MODE_64B_FIRST 8'h20
`define SLC_MODE_LOCK_MAX 8'h0F
`define SLC_K_64B_SCALE 8'h00
`define SLC_SYNC_STAGES 2

`endif

//--- include/slc_pkg.sv
// Types shared by the serial link control register bank.
// Assumes the constants header sits beside it on the include path.
package slc_pkg;
    `include "slc_cfg.svh"

    // Source of the link synchronization request
    typedef enum logic [1:0] {
        SLC_SRC_PIN = `SLC_SEL_PIN,
        SLC_SRC_MARKER = `SLC_SEL_MARKER,
        SLC_SRC_SOFTWARE = `SLC_SEL_SOFTWARE,
        SLC_SRC_NONE = 2'h3
    } slc_sync_src_t;

    // Whole state of the top module
    typedef struct packed {
        logic [7:0] sampleLsbControl;
        logic [7:0] linkSubsystemEnable;
        logic [7:0] linkModeSelect;
        logic [7:0] framesPerMultiframeMinusOne;
        logic [7:0] softwareSyncRequest;
        logic [7:0] syncControl;
        logic [7:0] rdData;
        logic linkReset;
        logic serializerPowerDown;
        logic linkClockEnable;
        logic multiframeCounterReset;
        logic syncRequest;
        logic [7:0] sampleOut;
        logic [1:0] ilaControlBits;
        logic modeIs64b;
        logic [9:0] framesPerMultiframe;
    } slc_state_t;
endpackage : slc_pkg

//--- rtl/slc_sync_2ff.sv
// Two-flop synchroniser for a bundle of unrelated pin levels.
// Assumes each bit is a slow level; no bit-to-bit coherence is promised.
`timescale 1ns/10ps
`default_nettype none
module slc_sync_2ff #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    // Metastable stage feeds only the stable stage
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } slc_sync_state_t;

    slc_sync_state_t q, d;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d.meta = asyncIn;
        d.stable = q.meta;
    end

    // ------------------------------------------------------------------
    // Registers; the sync pin idles high, so reset to ones avoids a false request
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end

    assign syncOut = q.stable;
endmodule : slc_sync_2ff
`default_nettype wire

//--- rtl/slc_delay_line.sv
// Fixed-depth register delay line used to balance path latencies.
// Assumes DEPTH of at least one; every stage runs on every edge.
`timescale 1ns/10ps
`default_nettype none
module slc_delay_line #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data in, data out DEPTH cycles later
    input wire logic [W-1:0] dataIn,
    output logic [W-1:0] dataOut
);
    // All stages held in one packed struct
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] stage;
    } slc_delay_state_t;

    slc_delay_state_t q, d;

    // ------------------------------------------------------------------
    // Shift one stage per edge
    // ------------------------------------------------------------------
    always_comb begin
        d.stage[0] = dataIn;
        for (int i = 1; i < DEPTH; i++) begin
            d.stage[i] = q.stage[i-1];
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dataOut = q.stage[DEPTH-1];
endmodule : slc_delay_line
`default_nettype wire

//--- rtl/slc_regs.sv
// Serial link control register bank: marker insertion on the sample LSB,
// link enable with its reset and power side effects, mode and K, and the
// synchronization request combiner.
// Assumes a same-clock register port, same-clock sample and status
// inputs, and asynchronous sync and marker pins.
`timescale 1ns/10ps
`default_nettype none
`include "slc_cfg.svh"
module slc_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [11:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    output logic [7:0] rdData,
    // Status from neighbouring blocks, same clock
    input wire logic calEnable,
    input wire logic modeLockEn,
    input wire logic ilaActive,
    input wire logic [7:0] linkE,
    input wire logic [7:0] linkF,
    // Converter samples, same clock
    input wire logic [7:0] sampleIn,
    // Asynchronous pins
    input wire logic dedicatedSyncPin_n,
    input wire logic markerPin,
    // Sample stream toward the link
    output logic [7:0] sampleOut,
    output logic [1:0] ilaControlBits,
    // Link subsystem controls
    output logic linkReset,
    output logic serializerPowerDown,
    output logic linkClockEnable,
    output logic multiframeCounterReset,
    output logic syncRequest,
    output logic [7:0] linkModeSelect,
    output logic modeIs64b,
    output logic [9:0] framesPerMultiframe
);
    import slc_pkg::*;

    slc_state_t q, d;              // Whole block state
    logic [1:0] pinSync;           // Synchronised sync pin and marker pin
    logic syncPinLow;              // Dedicated pin requesting
    logic markerLevel;             // Synchronised marker level
    logic [7:0] sampleAligned;     // Sample delayed to meet the marker
    logic linkOn;                  // Stored link enable
    logic modeWriteOk;             // Mode write allowed now
    logic modeAllowed;             // Candidate mode passes the lock
    logic pinRequest;              // Request from the selected pin
    slc_sync_src_t syncSrc;        // Selected request source
    logic [15:0] kQuot;            // 256*E/F before narrowing

    // ------------------------------------------------------------------
    // Pin synchronisers and latency balance
    // ------------------------------------------------------------------
    // Both pins share one synchroniser; each bit is a slow level.
    slc_sync_2ff #(
        .W(2)
    ) uPinSync (
        .clk(clk),
        .rst_n(rst_n),
        .asyncIn({dedicatedSyncPin_n, markerPin}),
        .syncOut(pinSync)
    );

    assign syncPinLow = ~pinSync[1];
    assign markerLevel = pinSync[0];
    // Marker stage also resets high; harmless, since insertion and the
    // marker source select are both off straight after reset.

    // Sample waits as long as the marker spends in the synchroniser
    slc_delay_line #(
        .W(8),
        .DEPTH(`SLC_SYNC_STAGES)
    ) uSampleDelay (
        .clk(clk),
        .rst_n(rst_n),
        .dataIn(sampleIn),
        .dataOut(sampleAligned)
    ); // R2

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    assign linkOn = q.linkSubsystemEnable[`SLC_BIT_LINK_EN];
    // Code 3 has no pin behind it, so it behaves like software only
    assign syncSrc = slc_sync_src_t'(q.syncControl[`SLC_SYNC_SEL_HI:`SLC_SYNC_SEL_LO]);

    always_comb begin
        d = q;
        // Read data stand for one cycle only
        d.rdData = 8'h00;

        // Lock caps the permitted mode codes
        modeAllowed = !modeLockEn || (wrData <= `SLC_MODE_LOCK_MAX); // R15
        // Mode changes refused while the link or calibration runs
        modeWriteOk = !linkOn && !calEnable && modeAllowed; // R14

        // Register writes; reserved bits stored as written
        if (wrEn) begin
            case (addr)
                `SLC_OFS_SAMPLE_LSB_CONTROL: begin
                    d.sampleLsbControl = wrData; // R23
                end
                `SLC_OFS_LINK_ENABLE: begin
                    d.linkSubsystemEnable = wrData; // R6
                end
                `SLC_OFS_LINK_MODE: begin
                    if (modeWriteOk) begin
                        d.linkModeSelect = wrData; // R13
                    end
                end
                `SLC_OFS_FRAMES_M1: begin
                    d.framesPerMultiframeMinusOne = wrData; // R16
                end
                `SLC_OFS_SW_SYNC: begin
                    d.softwareSyncRequest = wrData; // R19
                end
                `SLC_OFS_SYNC_CONTROL: begin
                    d.syncControl = wrData;
                end
                default: begin
                    // Unmapped writes are dropped
                end
            endcase
        end

        // Register reads, answered next cycle
        if (rdEn) begin
            case (addr)
                `SLC_OFS_SAMPLE_LSB_CONTROL: d.rdData = q.sampleLsbControl;
                `SLC_OFS_LINK_ENABLE: d.rdData = q.linkSubsystemEnable;
                `SLC_OFS_LINK_MODE: d.rdData = q.linkModeSelect;
                `SLC_OFS_FRAMES_M1: d.rdData = q.framesPerMultiframeMinusOne;
                `SLC_OFS_SW_SYNC: d.rdData = q.softwareSyncRequest;
                `SLC_OFS_SYNC_CONTROL: d.rdData = q.syncControl;
                default: d.rdData = 8'h00;
            endcase
        end

        // Disabled link: reset, powered down, no clocks, counter held reset
        d.linkReset = !linkOn; // R8
        d.serializerPowerDown = !linkOn; // R8
        d.linkClockEnable = linkOn; // R9
        d.multiframeCounterReset = !linkOn; // R10

        // Selected pin source; software-only selection releases the pin
        case (syncSrc)
            SLC_SRC_PIN: pinRequest = syncPinLow; // R22
            SLC_SRC_MARKER: pinRequest = !markerLevel; // R22
            SLC_SRC_SOFTWARE: pinRequest = 1'b0; // R22
            default: pinRequest = 1'b0;
        endcase
        // Software bit always able to request, ORed with the pin
        d.syncRequest = !q.softwareSyncRequest[`SLC_BIT_SW_SYNC] || pinRequest; // R20

        // Marker takes the LSB, seven data bits kept above it
        if (q.sampleLsbControl[`SLC_BIT_MARKER_EN]) begin
            d.sampleOut = {sampleAligned[7:1], markerLevel}; // R1 R3
        end else begin
            d.sampleOut = sampleAligned;
        end

        // Alignment sequence never advertises the control bit
        if (ilaActive) begin
            d.ilaControlBits = 2'h0; // R4
        end else begin
            d.ilaControlBits = {1'b0, q.sampleLsbControl[`SLC_BIT_MARKER_EN]};
        end

        // K from the register, or from E and F in 64b/66b modes
        d.modeIs64b = (q.linkModeSelect >= `SLC_MODE_64B_FIRST);
        // Zero F would divide by zero; K then reads as zero instead
        kQuot = 16'h0000;
        if (linkF != 8'h00) begin
            kQuot = {linkE, `SLC_K_64B_SCALE} / {8'h00, linkF};
        end
        if (d.modeIs64b) begin
            d.framesPerMultiframe = kQuot[9:0]; // R18
        end else begin
            d.framesPerMultiframe = {2'h0, q.framesPerMultiframeMinusOne} + 10'h001; // R16
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Outputs reset to the disabled-free state the link enable implies.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q.sampleLsbControl <= `SLC_RST_SAMPLE_LSB_CONTROL;
            q.linkSubsystemEnable <= `SLC_RST_LINK_ENABLE; // R6
            q.linkModeSelect <= `SLC_RST_LINK_MODE; // R13
            q.framesPerMultiframeMinusOne <= `SLC_RST_FRAMES_M1; // R16
            q.softwareSyncRequest <= `SLC_RST_SW_SYNC; // R19
            q.syncControl <= `SLC_RST_SYNC_CONTROL;
            q.rdData <= 8'h00;
            q.linkReset <= 1'b0;
            q.serializerPowerDown <= 1'b0;
            q.linkClockEnable <= 1'b1;
            q.multiframeCounterReset <= 1'b0;
            q.syncRequest <= 1'b0;
            q.sampleOut <= 8'h00;
            q.ilaControlBits <= 2'h0;
            q.modeIs64b <= 1'b0;
            q.framesPerMultiframe <= 10'h020;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign rdData = q.rdData;
    assign sampleOut = q.sampleOut;
    assign ilaControlBits = q.ilaControlBits;
    assign linkReset = q.linkReset;
    assign serializerPowerDown = q.serializerPowerDown;
    assign linkClockEnable = q.linkClockEnable;
    assign multiframeCounterReset = q.multiframeCounterReset;
    assign syncRequest = q.syncRequest;
    assign linkModeSelect = q.linkModeSelect;
    assign modeIs64b = q.modeIs64b;
    assign framesPerMultiframe = q.framesPerMultiframe;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Write of the enable register with bit zero clear
    sequence linkOffWrite;
        wrEn && (addr == `SLC_OFS_LINK_ENABLE) && !wrData[0];
    endsequence

    // Disabled link shows all four side effects two cycles on
    linkOffEffects_a: assert property (linkOffWrite |-> ##2 // R8
        (linkReset && serializerPowerDown && !linkClockEnable && multiframeCounterReset))
        else $error("Link disable side effects missing");

    // Write of the enable register with bit zero set
    sequence linkOnWrite;
        wrEn && (addr == `SLC_OFS_LINK_ENABLE) && wrData[0];
    endsequence

    // Enabled link leaves reset, powers up and runs its clocks
    linkOnEffects_a: assert property (linkOnWrite |-> ##2 // R6
        (!linkReset && !serializerPowerDown && linkClockEnable && !multiframeCounterReset))
        else $error("Link enable side effects missing");

    // Gated clock and counter reset always move together
    clockGateTie_a: assert property (linkClockEnable == !multiframeCounterReset) // R9
        else $error("Clock gate and counter reset disagree");

    // Marker occupies the LSB while insertion stays on
    markerLsb_a: assert property ($past(q.sampleLsbControl[0]) // R1
        |-> sampleOut[0] == $past(markerLevel))
        else $error("Marker not on sample LSB");

    // Seven data bits kept above the marker
    sampleUpper_a: assert property (1'b1 |=> sampleOut[7:1] == $past(sampleAligned[7:1])) // R3
        else $error("Upper sample bits corrupted");

    // Alignment sequence advertises no control bits
    ilaZero_a: assert property (ilaActive |=> ilaControlBits == 2'h0) // R4
        else $error("Control bits advertised during alignment");

    // Mode register refuses writes while the link runs
    modeHold_a: assert property ((wrEn && addr == `SLC_OFS_LINK_MODE && linkOn) // R14
        |=> $stable(q.linkModeSelect))
        else $error("Mode changed with link enabled");

    // Mode register refuses writes while calibration runs
    modeCalHold_a: assert property ((wrEn && addr == `SLC_OFS_LINK_MODE && calEnable) // R14
        |=> $stable(q.linkModeSelect))
        else $error("Mode changed with calibration enabled");

    // Lock refuses codes above its ceiling
    modeLockRefuse_a: assert property ((wrEn && addr == `SLC_OFS_LINK_MODE && modeLockEn // R15
        && wrData > `SLC_MODE_LOCK_MAX) |=> $stable(q.linkModeSelect))
        else $error("Locked mode accepted");

    // Frames count equals stored value plus one outside 64b/66b
    kFromReg_a: assert property (!d.modeIs64b // R16
        |=> framesPerMultiframe == {2'h0, $past(q.framesPerMultiframeMinusOne)} + 10'h001)
        else $error("K does not equal register plus one");

    // Software request bit cleared raises the request two cycles on
    sequence swSyncClear;
        wrEn && (addr == `SLC_OFS_SW_SYNC) && !wrData[0];
    endsequence
    swSyncReq_a: assert property (swSyncClear |-> ##2 syncRequest) // R19 R20
        else $error("Software sync request not raised");

    // Stuck-low dedicated pin keeps the request while selected
    pinStuck_a: assert property ((syncSrc == SLC_SRC_PIN && syncPinLow) |=> syncRequest) // R21
        else $error("Selected pin low without request");

    // Software-only source with the bit high releases the request
    swRelease_a: assert property ((syncSrc == SLC_SRC_SOFTWARE // R22
        && q.softwareSyncRequest[0]) |=> !syncRequest)
        else $error("Request held with software source idle");
endmodule : slc_regs
`default_nettype wire

//--- sim/slc_far_side_model.sv
// Far-side model: the link receiver that drives the sync pin, and the marker source.
// Assumes the bench asks for levels; pins move 3 ns after a request, off the edge.
`timescale 1ns/10ps
`default_nettype none
module slc_far_side_model (
    // Requests from the bench
    input wire logic wantSync,
    input wire logic markerLevel,
    // Pins toward the block
    output logic dedicatedSyncPin_n,
    output logic markerPin
);
    // Idle pins: no sync request, marker low
    initial begin
        dedicatedSyncPin_n = 1'b1;
        markerPin = 1'b0;
    end
    // Skewed pin drive, so the synchroniser never sees a change on an edge
    always @(wantSync) dedicatedSyncPin_n <= #3 ~wantSync;
    always @(markerLevel) markerPin <= #3 markerLevel;
endmodule : slc_far_side_model
`default_nettype wire

//--- sim/slc_regs_tb.sv
// Self-checking bench for the serial link control register bank.
// Assumes slc_pkg, slc_cfg.svh on the include path, and the far-side model.
`timescale 1ns/10ps
`default_nettype none
`include "slc_cfg.svh"
`define SLC_CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); n_mismatch++; end end
module slc_regs_tb;
    import slc_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clk, rst_n, wrEn, rdEn, calEnable, modeLockEn, ilaActive;
    logic [11:0] addr;
    logic [7:0] wrData, rdData, linkE, linkF, sampleIn, sampleOut, linkModeSelect;
    logic dedicatedSyncPin_n, markerPin, wantSync, markerLevel;
    logic [1:0] ilaControlBits;
    logic linkReset, serializerPowerDown, linkClockEnable, multiframeCounterReset;
    logic syncRequest, modeIs64b;
    logic [9:0] framesPerMultiframe;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;
    // Block under test and its far side
    slc_regs uut (.clk, .rst_n, .addr, .wrData, .wrEn, .rdEn, .rdData, .calEnable,
        .modeLockEn, .ilaActive, .linkE, .linkF, .sampleIn, .dedicatedSyncPin_n,
        .markerPin, .sampleOut, .ilaControlBits, .linkReset, .serializerPowerDown,
        .linkClockEnable, .multiframeCounterReset, .syncRequest, .linkModeSelect,
        .modeIs64b, .framesPerMultiframe);
    slc_far_side_model far (.wantSync, .markerLevel, .dedicatedSyncPin_n, .markerPin);
    // ------------------------------------------------------------------
    // Clock, timeout and tasks
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run is about 120 cycles; the ceiling leaves ample slack
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out
    // Let n edges pass, then settle past them
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // One-cycle write strobe
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge clk);
        wrEn <= 1'b0;
    endtask : wr
    // One-cycle read strobe; data looked at only in the following cycle
    task automatic rdChk(input string nm, input logic [11:0] a, input logic [7:0] ex);
        @(posedge clk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clk);
        rdEn <= 1'b0;
        #1;
        `SLC_CHK(nm, ex, rdData)
    endtask : rdChk
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        {addr, wrData, wrEn, rdEn, modeLockEn, ilaActive, sampleIn} = '0;
        {wantSync, markerLevel} = 2'b00;
        calEnable = 1'b1;
        linkE = 8'h02;
        linkF = 8'h04;
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        // Reset values, reserved storage, unmapped place
        rdChk("sample_lsb_control", 12'h160, 8'h00);
        rdChk("link_subsystem_enable", 12'h200, 8'h01);
        rdChk("link_mode_select", 12'h201, 8'h02);
        rdChk("frames_per_multiframe_minus_one", 12'h202, 8'h1F);
        rdChk("software_sync_request", 12'h203, 8'h01);
        rdChk("sync source select", 12'h204, 8'h00);
        `SLC_CHK("K after reset", 10'd32, framesPerMultiframe)
        wr(12'h200, 8'hA5);
        rdChk("link enable reserved bits", 12'h200, 8'hA5);
        wr(12'h205, 8'hFF);
        rdChk("unmapped", 12'h205, 8'h00);
        $display("test reset done");
        // Marker on the sample LSB, exact latency, alignment CS
        wr(12'h160, 8'h01);
        @(posedge clk);
        sampleIn <= 8'hAA;
        markerLevel <= 1'b1;
        tick(2);
        `SLC_CHK("sample before latency", 8'h00, sampleOut)
        tick(1);
        `SLC_CHK("marked sample", 8'hAB, sampleOut)
        sampleIn <= 8'h57;
        markerLevel <= 1'b0;
        tick(4);
        `SLC_CHK("cleared marker", 8'h56, sampleOut)
        `SLC_CHK("CS outside alignment", 2'h1, ilaControlBits)
        ilaActive <= 1'b1;
        tick(2);
        `SLC_CHK("CS in alignment", 2'h0, ilaControlBits)
        ilaActive <= 1'b0;
        wr(12'h160, 8'h00);
        tick(4);
        `SLC_CHK("unmarked sample", 8'h57, sampleOut)
        $display("test marker done");
        // Link disable side effects, mode refusals, K
        wr(12'h201, 8'h05);
        rdChk("mode while linked", 12'h201, 8'h02);
        wr(12'h200, 8'h00);
        tick(2);
        `SLC_CHK("link reset", 1'b1, linkReset)
        `SLC_CHK("power down", 1'b1, serializerPowerDown)
        `SLC_CHK("clock gated", 1'b0, linkClockEnable)
        `SLC_CHK("counter reset", 1'b1, multiframeCounterReset)
        wr(12'h201, 8'h05);
        rdChk("mode while cal on", 12'h201, 8'h02);
        calEnable <= 1'b0;
        wr(12'h201, 8'h05);
        rdChk("mode accepted", 12'h201, 8'h05);
        modeLockEn <= 1'b1;
        wr(12'h201, 8'h10);
        rdChk("locked mode refused", 12'h201, 8'h05);
        wr(12'h201, 8'h0F);
        rdChk("locked mode allowed", 12'h201, 8'h0F);
        modeLockEn <= 1'b0;
        wr(12'h201, 8'h20);
        wr(12'h202, 8'h0F);
        tick(2);
        `SLC_CHK("64b flag", 1'b1, modeIs64b)
        `SLC_CHK("64b K", 10'd128, framesPerMultiframe)
        wr(12'h201, 8'h02);
        tick(2);
        `SLC_CHK("mode output", 8'h02, linkModeSelect)
        `SLC_CHK("programmed K", 10'd16, framesPerMultiframe)
        `SLC_CHK("64b flag off", 1'b0, modeIs64b)
        calEnable <= 1'b1;
        wr(12'h200, 8'h01);
        tick(2);
        `SLC_CHK("link out of reset", 1'b0, linkReset)
        `SLC_CHK("clock running", 1'b1, linkClockEnable)
        $display("test link done");
        // Synchronization request sources
        `SLC_CHK("no request", 1'b0, syncRequest)
        wr(12'h203, 8'h00);
        tick(2);
        `SLC_CHK("software request", 1'b1, syncRequest)
        wr(12'h203, 8'h01);
        tick(2);
        `SLC_CHK("software release", 1'b0, syncRequest)
        wantSync <= 1'b1;
        tick(5);
        `SLC_CHK("pin request", 1'b1, syncRequest)
        wr(12'h204, 8'h08);
        tick(3);
        `SLC_CHK("software only select", 1'b0, syncRequest)
        wr(12'h203, 8'h00);
        tick(2);
        `SLC_CHK("software under select 2", 1'b1, syncRequest)
        wr(12'h203, 8'h01);
        wr(12'h204, 8'h04);
        tick(3);
        `SLC_CHK("marker pin low request", 1'b1, syncRequest)
        markerLevel <= 1'b1;
        tick(5);
        `SLC_CHK("marker pin high", 1'b0, syncRequest)
        markerLevel <= 1'b0;
        wr(12'h204, 8'h0C);
        tick(5);
        `SLC_CHK("select 3 ignores pins", 1'b0, syncRequest)
        $display("test sync done");
        close_out();
    end
endmodule : slc_regs_tb
`default_nettype wire
